// File: design/pllcd_pkg.sv
// Constants for the PLL clock divider control block.
// Assumes a 10 MHz system clock and a plain strobe-based register port.
package pllcd_pkg;
	// Register port geometry
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	// Register offsets
	localparam logic [3:0] CTRL_ADDR = 4'h0;
	localparam logic [3:0] DIVIDERS_ADDR = 4'h1;
	localparam logic [3:0] STATUS_ADDR = 4'h2;
	// Control register fields
	localparam int CTRL_OSC_BIT = 0;
	localparam int CTRL_PLL_SELECT_BIT = 1;
	// Dividers register fields
	localparam int REF_DIVIDER_FIELD_LSB = 0;
	localparam int REF_DIVIDER_FIELD_W = 4;
	localparam int LOOP_MULTIPLIER_FIELD_LSB = 8;
	localparam int LOOP_MULTIPLIER_FIELD_W = 6;
	localparam int POST_DIVIDER_FIELD_LSB = 16;
	localparam int POST_DIVIDER_FIELD_W = 5;
	// Status register fields
	localparam int STAT_LOCK_BIT = 0;
	localparam int STAT_OSC_BIT = 1;
	localparam int STAT_PLL_SELECT_BIT = 2;
	// Reset values
	localparam logic RST_OSC_ENABLE = 1'b0;
	localparam logic RST_PLL_SELECT = 1'b0;
	localparam logic [3:0] RST_REF_DIVIDER_FIELD = 4'h0;
	localparam logic [5:0] RST_LOOP_MULTIPLIER_FIELD = 6'h18;
	localparam logic [4:0] RST_POST_DIVIDER_FIELD = 5'h03;
	// Fixed divide values, written as terminal count (divide minus one)
	localparam logic [4:0] UNLOCKED_POST_TC = 5'h03;
	localparam logic [6:0] BUS_TC = 7'h01;
	// Width of the feedback and bus divider counters
	localparam int CNT_W = 7;
endpackage : pllcd_pkg

// File: design/pllcd_top.sv
// PLL clock divider control: reference select, feedback, post and bus dividers.
// Assumes all clocks arrive as one-cycle ticks synchronous to sys_clk.
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/10ps

module pllcd_div #(
	parameter int W = 7
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Divider
	input wire logic tick_in,
	input wire logic [W-1:0] term,
	output logic tick_out,
	output logic [W-1:0] count
);
	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;
	logic wrap;

	// Wrap on >= so a smaller setting never strands the counter
	assign wrap = tick_in && (cnt_reg >= term);
	assign cnt_next = wrap ? '0 : (tick_in ? cnt_reg + 1'b1 : cnt_reg);
	assign tick_out = wrap;
	assign count = cnt_reg;

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end
endmodule : pllcd_div

module pllcd_top (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Register port
	input wire logic [pllcd_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [pllcd_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [pllcd_pkg::DATA_W-1:0] reg_rdata,
	// Source clock ticks and loop status
	input wire logic internal_rc_clock,
	input wire logic oscillator_clock,
	input wire logic vco_clock,
	input wire logic pll_lock,
	// Derived clock ticks
	output logic reference_clock,
	output logic feedback_clock,
	output logic pll_output_clock,
	output logic bus_clock
);
	import pllcd_pkg::*;

	logic osc_enable_reg;
	logic pll_select_reg;
	logic [REF_DIVIDER_FIELD_W-1:0] ref_divider_field_reg;
	logic [LOOP_MULTIPLIER_FIELD_W-1:0] loop_multiplier_field_reg;
	logic [POST_DIVIDER_FIELD_W-1:0] post_divider_field_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic [DATA_W-1:0] rdata_next;
	logic ref_reg;
	logic fb_reg;
	logic pll_reg;
	logic bus_reg;

	// Register decode
	wire wr_ctrl = reg_wr && (reg_addr == CTRL_ADDR);
	wire wr_div = reg_wr && (reg_addr == DIVIDERS_ADDR);
	wire [DATA_W-1:0] ctrl_view = {{(DATA_W-2){1'b0}}, pll_select_reg, osc_enable_reg};
	wire [DATA_W-1:0] div_view = {11'h000, post_divider_field_reg, 2'h0,
		loop_multiplier_field_reg, 4'h0, ref_divider_field_reg};
	wire [DATA_W-1:0] stat_view = {{(DATA_W-3){1'b0}}, pll_select_reg, osc_enable_reg,
		pll_lock};

	// Unmapped addresses read as zero
	assign rdata_next = !reg_rd ? '0 :
		(reg_addr == CTRL_ADDR) ? ctrl_view :
		(reg_addr == DIVIDERS_ADDR) ? div_view :
		(reg_addr == STATUS_ADDR) ? stat_view : '0;

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			osc_enable_reg <= RST_OSC_ENABLE;
			pll_select_reg <= RST_PLL_SELECT;
			ref_divider_field_reg <= RST_REF_DIVIDER_FIELD;
			loop_multiplier_field_reg <= RST_LOOP_MULTIPLIER_FIELD;
			post_divider_field_reg <= RST_POST_DIVIDER_FIELD;
			rdata_reg <= '0;
		end else begin
			if (wr_ctrl) begin
				osc_enable_reg <= reg_wdata[CTRL_OSC_BIT];
				pll_select_reg <= reg_wdata[CTRL_PLL_SELECT_BIT];
			end
			if (wr_div) begin
				ref_divider_field_reg <= reg_wdata[REF_DIVIDER_FIELD_LSB +: REF_DIVIDER_FIELD_W];
				loop_multiplier_field_reg <= reg_wdata[LOOP_MULTIPLIER_FIELD_LSB +: LOOP_MULTIPLIER_FIELD_W];
				post_divider_field_reg <= reg_wdata[POST_DIVIDER_FIELD_LSB +: POST_DIVIDER_FIELD_W];
			end
			rdata_reg <= rdata_next;
		end
	end
	assign reg_rdata = rdata_reg;

	// Reference path
	logic osc_div_tick;
	logic [REF_DIVIDER_FIELD_W-1:0] ref_cnt;
	pllcd_div #(.W(REF_DIVIDER_FIELD_W)) u_ref_div (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.tick_in(oscillator_clock),
		.term(ref_divider_field_reg),
		.tick_out(osc_div_tick),
		.count(ref_cnt)
	);
	wire ref_next = osc_enable_reg ? osc_div_tick : internal_rc_clock;

	// Feedback: terminal count 2*(m+1)-1 gives the even multiply
	logic fb_tick;
	logic [CNT_W-1:0] fb_cnt;
	wire [CNT_W-1:0] fb_term = {loop_multiplier_field_reg, 1'b1};
	pllcd_div #(.W(CNT_W)) u_fb_div (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.tick_in(vco_clock),
		.term(fb_term),
		.tick_out(fb_tick),
		.count(fb_cnt)
	);

	// Post divider, forced to four while unlocked
	logic post_tick;
	logic [POST_DIVIDER_FIELD_W-1:0] post_cnt;
	wire [POST_DIVIDER_FIELD_W-1:0] post_term = pll_lock ? post_divider_field_reg
		: UNLOCKED_POST_TC;
	pllcd_div #(.W(POST_DIVIDER_FIELD_W)) u_post_div (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.tick_in(vco_clock),
		.term(post_term),
		.tick_out(post_tick),
		.count(post_cnt)
	);

	// Bus clock always halves its source, keeping it under the limit in bypass
	logic bus_tick;
	logic [CNT_W-1:0] bus_cnt;
	wire bus_src = pll_select_reg ? pll_reg : ref_reg;
	pllcd_div #(.W(CNT_W)) u_bus_div (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.tick_in(bus_src),
		.term(BUS_TC),
		.tick_out(bus_tick),
		.count(bus_cnt)
	);

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			ref_reg <= 1'b0;
			fb_reg <= 1'b0;
			pll_reg <= 1'b0;
			bus_reg <= 1'b0;
		end else begin
			ref_reg <= ref_next;
			fb_reg <= fb_tick;
			pll_reg <= post_tick;
			bus_reg <= bus_tick;
		end
	end
	assign reference_clock = ref_reg;
	assign feedback_clock = fb_reg;
	assign pll_output_clock = pll_reg;
	assign bus_clock = bus_reg;

	// Checks
	sequence s_ctrl_read;
		reg_rd && (reg_addr == CTRL_ADDR);
	endsequence

	property p_ctrl_readback;
		@(posedge sys_clk) disable iff (!rst_b)
		s_ctrl_read |=> reg_rdata[CTRL_OSC_BIT] == $past(osc_enable_reg)
			&& reg_rdata[CTRL_PLL_SELECT_BIT] == $past(pll_select_reg);
	endproperty
	a_ctrl_readback: assert property (p_ctrl_readback) else $error("control readback wrong");

	property p_rc_ref;
		@(posedge sys_clk) disable iff (!rst_b)
		(!osc_enable_reg && internal_rc_clock) |=> reference_clock;
	endproperty
	a_rc_ref: assert property (p_rc_ref) else $error("rc tick not passed to reference");

	property p_rc_only;
		@(posedge sys_clk) disable iff (!rst_b)
		(reference_clock && !$past(osc_enable_reg)) |-> $past(internal_rc_clock);
	endproperty
	a_rc_only: assert property (p_rc_only) else $error("reference tick without rc tick");

	property p_osc_div;
		@(posedge sys_clk) disable iff (!rst_b)
		(reference_clock && $past(osc_enable_reg)) |->
			$past(oscillator_clock) && ($past(ref_cnt) >= $past(ref_divider_field_reg));
	endproperty
	a_osc_div: assert property (p_osc_div) else $error("oscillator divide wrong");

	property p_fb_div;
		@(posedge sys_clk) disable iff (!rst_b)
		feedback_clock |-> $past(vco_clock) && ($past(fb_cnt) >= $past(fb_term));
	endproperty
	a_fb_div: assert property (p_fb_div) else $error("feedback divide wrong");

	property p_post_locked;
		@(posedge sys_clk) disable iff (!rst_b)
		(pll_output_clock && $past(pll_lock)) |->
			($past(post_cnt) >= $past(post_divider_field_reg));
	endproperty
	a_post_locked: assert property (p_post_locked) else $error("locked post divide wrong");

	property p_post_unlocked;
		@(posedge sys_clk) disable iff (!rst_b)
		(pll_output_clock && !$past(pll_lock)) |->
			$past(vco_clock) && ($past(post_cnt) >= UNLOCKED_POST_TC);
	endproperty
	a_post_unlocked: assert property (p_post_unlocked) else $error("unlocked divide not four");

	property p_bus_pll;
		@(posedge sys_clk) disable iff (!rst_b)
		(bus_clock && $past(pll_select_reg)) |->
			$past(pll_output_clock) && ($past(bus_cnt) >= BUS_TC);
	endproperty
	a_bus_pll: assert property (p_bus_pll) else $error("bus not half of pll clock");

	property p_bus_ref;
		@(posedge sys_clk) disable iff (!rst_b)
		(bus_clock && !$past(pll_select_reg)) |->
			$past(reference_clock) && ($past(bus_cnt) >= BUS_TC);
	endproperty
	a_bus_ref: assert property (p_bus_ref) else $error("bus not half of reference");

	property p_osc_direct;
		@(posedge sys_clk) disable iff (!rst_b)
		(osc_enable_reg && oscillator_clock && ref_divider_field_reg == 4'h0) |=> reference_clock;
	endproperty
	a_osc_direct: assert property (p_osc_direct) else $error("undivided osc tick lost");

	property p_fb_fwd;
		@(posedge sys_clk) disable iff (!rst_b)
		(vco_clock && (fb_cnt >= fb_term)) |=> feedback_clock;
	endproperty
	a_fb_fwd: assert property (p_fb_fwd) else $error("feedback tick missing");

	// Forward halves: a completed count must always give a tick
	sequence s_post_wrap_lk;
		pll_lock && vco_clock && (post_cnt >= post_divider_field_reg);
	endsequence
	sequence s_post_wrap_ul;
		!pll_lock && vco_clock && (post_cnt >= UNLOCKED_POST_TC);
	endsequence

	property p_post_lk_fwd;
		@(posedge sys_clk) disable iff (!rst_b)
		s_post_wrap_lk |=> pll_output_clock;
	endproperty
	a_post_lk_fwd: assert property (p_post_lk_fwd) else $error("locked tick missing");

	property p_post_ul_fwd;
		@(posedge sys_clk) disable iff (!rst_b)
		s_post_wrap_ul |=> pll_output_clock;
	endproperty
	a_post_ul_fwd: assert property (p_post_ul_fwd) else $error("unlocked tick missing");

	sequence s_bus_wrap;
		bus_cnt >= BUS_TC;
	endsequence
	property p_bus_pll_fwd;
		@(posedge sys_clk) disable iff (!rst_b)
		(pll_select_reg && pll_output_clock) ##0 s_bus_wrap |=> bus_clock;
	endproperty
	a_bus_pll_fwd: assert property (p_bus_pll_fwd) else $error("bus tick missing");

	property p_bus_ref_fwd;
		@(posedge sys_clk) disable iff (!rst_b)
		(!pll_select_reg && reference_clock) ##0 s_bus_wrap |=> bus_clock;
	endproperty
	a_bus_ref_fwd: assert property (p_bus_ref_fwd) else $error("bypass bus tick missing");

	sequence s_div_read;
		reg_rd && (reg_addr == DIVIDERS_ADDR);
	endsequence
	property p_div_rb;
		@(posedge sys_clk) disable iff (!rst_b)
		s_div_read |=> reg_rdata[REF_DIVIDER_FIELD_LSB +: REF_DIVIDER_FIELD_W] == $past(ref_divider_field_reg)
			&& reg_rdata[LOOP_MULTIPLIER_FIELD_LSB +: LOOP_MULTIPLIER_FIELD_W] == $past(loop_multiplier_field_reg)
			&& reg_rdata[POST_DIVIDER_FIELD_LSB +: POST_DIVIDER_FIELD_W] == $past(post_divider_field_reg);
	endproperty
	a_div_rb: assert property (p_div_rb) else $error("dividers readback");

	sequence s_stat_read;
		reg_rd && (reg_addr == STATUS_ADDR);
	endsequence
	property p_stat_rb;
		@(posedge sys_clk) disable iff (!rst_b)
		s_stat_read |=> reg_rdata[STAT_LOCK_BIT] == $past(pll_lock)
			&& reg_rdata[STAT_OSC_BIT] == $past(osc_enable_reg)
			&& reg_rdata[STAT_PLL_SELECT_BIT] == $past(pll_select_reg);
	endproperty
	a_stat_rb: assert property (p_stat_rb) else $error("status readback wrong");

	// Stale read data must not linger into a later cycle
	property p_rdata_idle;
		@(posedge sys_clk) disable iff (!rst_b)
		!reg_rd |=> reg_rdata == '0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared");

	property p_reset_quiet;
		@(posedge sys_clk)
		!rst_b |=> !reference_clock && !feedback_clock && !pll_output_clock && !bus_clock
			&& (reg_rdata == '0);
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("output active in reset");
endmodule : pllcd_top

// File: bench/tb.sv
// Self-checking bench for the PLL clock divider control block.
// Assumes steady ticks (oscillator and VCO every cycle, RC every other) give exact pulse counts over a fixed window.
`timescale 1ns/10ps
module tb;
	import pllcd_pkg::*;
	typedef struct packed {
		logic osc; logic sel; logic lock; logic [3:0] rd; logic [5:0] m; logic [4:0] p;
		logic [11:0] e_ref; logic [11:0] e_fb; logic [11:0] e_pll; logic [11:0] e_bus;
	} pllcd_row_s;
	// Window divisible by every divide used in the rows
	localparam int WIN = 3200;
	pllcd_row_s rows [6];
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [DATA_W-1:0] reg_rdata;
	logic rc = 1'b0, osc = 1'b0, vco = 1'b0, lock = 1'b0, run = 1'b0, ph = 1'b0, cnt_en = 1'b0;
	logic reference_clock, feedback_clock, pll_output_clock, bus_clock;
	integer c_ref, c_fb, c_pll, c_bus;
	int err_count = 0, n_tests = 0;
	always #50 sys_clk = ~sys_clk;
	// RC ticks at half rate so its path differs from the oscillator's
	always @(posedge sys_clk) begin
		ph <= ~ph;
		rc <= run & ph;
		osc <= run;
		vco <= run;
	end
	always @(posedge sys_clk) begin
		if (cnt_en) begin
			c_ref <= c_ref + reference_clock;
			c_fb <= c_fb + feedback_clock;
			c_pll <= c_pll + pll_output_clock;
			c_bus <= c_bus + bus_clock;
		end
	end
	pllcd_top DUT (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .internal_rc_clock(rc),
		.oscillator_clock(osc), .vco_clock(vco), .pll_lock(lock),
		.reference_clock(reference_clock), .feedback_clock(feedback_clock),
		.pll_output_clock(pll_output_clock), .bus_clock(bus_clock));
	task chk_reg(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t reg got %h exp %h", $time, got, exp);
		end
	endtask : chk_reg
	task chk_cnt(input integer got, input logic [11:0] exp);
		n_tests++;
		if (got !== {20'h0, exp}) begin
			err_count++;
			$display("BAD %0t pulse count %0d exp %0d", $time, got, exp);
		end
	endtask : chk_cnt
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task rd_chk(input logic [3:0] a, input logic [31:0] exp);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk_reg(reg_rdata, exp);
	endtask : rd_chk
	task test_done;
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : test_done
	initial begin
		#4_000_000;
		err_count++;
		test_done();
	end
	initial begin
		rows[0] = '{1'b0, 1'b0, 1'b0, 4'h0, 6'h18, 5'h03, 12'd1600, 12'd64, 12'd800, 12'd800};
		// Lowest multiplier with the undivided, fastest reference
		rows[1] = '{1'b1, 1'b1, 1'b1, 4'h0, 6'h00, 5'h00, 12'd3200, 12'd1600, 12'd3200, 12'd1600};
		rows[2] = '{1'b1, 1'b0, 1'b1, 4'hF, 6'h3F, 5'h1F, 12'd200, 12'd25, 12'd100, 12'd100};
		rows[3] = '{1'b1, 1'b1, 1'b0, 4'h3, 6'h01, 5'h1F, 12'd800, 12'd800, 12'd800, 12'd400};
		rows[4] = '{1'b0, 1'b1, 1'b1, 4'h7, 6'h18, 5'h04, 12'd1600, 12'd64, 12'd640, 12'd320};
		rows[5] = '{1'b1, 1'b1, 1'b1, 4'h4, 6'h3F, 5'h07, 12'd640, 12'd25, 12'd400, 12'd200};
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'b1;
		run <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			wr(CTRL_ADDR, {30'h0, rows[i].sel, rows[i].osc});
			wr(DIVIDERS_ADDR, {11'h0, rows[i].p, 2'h0, rows[i].m, 4'h0, rows[i].rd});
			lock <= rows[i].lock;
			// Settle past any counter wrap from the old setting
			repeat (200) @(posedge sys_clk);
			#1 {c_ref, c_fb, c_pll, c_bus} = '0;
			cnt_en = 1'b1;
			repeat (WIN) @(posedge sys_clk);
			#1 cnt_en = 1'b0;
			chk_cnt(c_ref, rows[i].e_ref);
			chk_cnt(c_fb, rows[i].e_fb);
			chk_cnt(c_pll, rows[i].e_pll);
			chk_cnt(c_bus, rows[i].e_bus);
			rd_chk(STATUS_ADDR, {29'h0, rows[i].sel, rows[i].osc, rows[i].lock});
			rd_chk(CTRL_ADDR, {30'h0, rows[i].sel, rows[i].osc});
			$display("row %0d done", i);
		end
		// Reserved bits, unmapped place, read-only status
		wr(DIVIDERS_ADDR, 32'hFFFFFFFF);
		rd_chk(DIVIDERS_ADDR, 32'h001F3F0F);
		wr(4'hF, 32'hFFFFFFFF);
		rd_chk(4'hF, 32'h00000000);
		wr(STATUS_ADDR, 32'h00000000);
		rd_chk(STATUS_ADDR, 32'h00000007);
		$display("register access test done");
		// Second reset with ticks still running
		@(posedge sys_clk);
		rst_b <= 1'b0;
		repeat (2) begin
			@(posedge sys_clk);
			#1 chk_reg({28'h0, reference_clock, feedback_clock, pll_output_clock, bus_clock}, '0);
		end
		@(posedge sys_clk);
		rst_b <= 1'b1;
		rd_chk(CTRL_ADDR, 32'h00000000);
		rd_chk(DIVIDERS_ADDR, {11'h0, RST_POST_DIVIDER_FIELD, 2'h0, RST_LOOP_MULTIPLIER_FIELD, 4'h0, RST_REF_DIVIDER_FIELD});
		$display("reset test done");
		test_done();
	end
endmodule : tb
